// ---- dtrf_params.svh ----
// Constants of the dual temperature result formatter: offsets, fields, resets, timing.
`ifndef DTRF_PARAMS_SVH
`define DTRF_PARAMS_SVH

// Register offsets; results, configuration and rate are fixed, limits are placed here.
`define DTRF_A_LOCAL 8'h00
`define DTRF_A_REM_INT 8'h01
`define DTRF_A_CFG_RD 8'h03
`define DTRF_A_RATE_RD 8'h04
`define DTRF_A_LHI_RD 8'h05
`define DTRF_A_LLO_RD 8'h06
`define DTRF_A_RHI_H_RD 8'h07
`define DTRF_A_RLO_H_RD 8'h08
`define DTRF_A_CFG_WR 8'h09
`define DTRF_A_RATE_WR 8'h0A
`define DTRF_A_LHI_WR 8'h0B
`define DTRF_A_LLO_WR 8'h0C
`define DTRF_A_RHI_H_WR 8'h0D
`define DTRF_A_RLO_H_WR 8'h0E
`define DTRF_A_REM_FRAC 8'h10
`define DTRF_A_RHI_L 8'h13
`define DTRF_A_RLO_L 8'h14

// Configuration fields and reset values.
`define DTRF_CFG_RANGE 2
`define DTRF_CFG_STANDBY 6
`define DTRF_CFG_WMASK 8'hE4
`define DTRF_CFG_RST 8'h00
`define DTRF_RATE_RST 8'h08
`define DTRF_RATE_MASK 8'h0F
`define DTRF_RES_RST 8'h00
`define DTRF_AVG_MAX_CODE 4'h7
`define DTRF_AVG_LAST 4'hF

// Limit storage index and reset values.
`define DTRF_LIM_LHI 3'h0
`define DTRF_LIM_LLO 3'h1
`define DTRF_LIM_RHI_H 3'h2
`define DTRF_LIM_RHI_L 3'h3
`define DTRF_LIM_RLO_H 3'h4
`define DTRF_LIM_RLO_L 3'h5
`define DTRF_LIM_NUM 6
`define DTRF_LIM_HI_RST 8'h55
`define DTRF_LIM_LO_RST 8'h00

// Data format constants.
`define DTRF_BIN_MAX 8'h7F
`define DTRF_EXT_MAX 8'hFF
`define DTRF_EXT_OFS 11'h040
`define DTRF_FRAC_PAD 6'h00

// Excitation step time and its cycle count at the system clock.
`define DTRF_CLK_NS 10
`define DTRF_PHASE_NS 1000
`define DTRF_PHASE_CYC ((`DTRF_PHASE_NS + `DTRF_CLK_NS - 1) / `DTRF_CLK_NS)

`endif

// ---- dtrf_pkg.sv ----
// Types shared by the dual temperature result formatter modules.
package dtrf_pkg;

    // Sequencer states, Gray coded along the measurement path.
    typedef enum logic [2:0] {
        DTRF_IDLE = 3'h0,
        DTRF_BASE1 = 3'h1,
        DTRF_MULT1 = 3'h3,
        DTRF_BASE2 = 3'h2,
        DTRF_MULT2 = 3'h6,
        DTRF_CONV = 3'h7
    } dtrf_state_t;

    // Diode excitation current selection.
    typedef enum logic [1:0] {
        DTRF_EXC_BASE = 2'h0,
        DTRF_EXC_N1 = 2'h1,
        DTRF_EXC_N2 = 2'h2
    } dtrf_exc_t;

    // One converter result in quarter degrees, two's complement.
    typedef struct packed {
        logic valid;
        logic short_flag;
        logic signed [11:0] temp;
    } dtrf_sample_t;

    // A formatted result: integer byte and fraction byte.
    typedef struct packed {
        logic [7:0] int_b;
        logic [7:0] frac_b;
    } dtrf_result_t;

    // Limit comparison outcome.
    typedef struct packed {
        logic loc_high;
        logic loc_low;
        logic rem_high;
        logic rem_low;
    } dtrf_flags_t;

endpackage

// ---- dtrf_averager.sv ----
// Sixteen-sample averager with a pass-through mode for the fast conversion rates.
`timescale 1ns/10ps
`include "dtrf_params.svh"

module dtrf_averager import dtrf_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic signed [11:0] in_temp,
    input wire logic avg_en,
    output logic out_valid,
    output logic signed [11:0] out_temp
);
    logic signed [15:0] acc_r, acc_nxt, sum;
    logic [3:0] cnt_r, cnt_nxt;
    logic ov_r, ov_nxt;
    logic signed [11:0] ot_r, ot_nxt;

    // Sixteen 12-bit samples fit in 16 bits, so the sum never wraps.
    always_comb begin
        sum = acc_r + {{4{in_temp[11]}}, in_temp};
        acc_nxt = acc_r;
        cnt_nxt = cnt_r;
        ov_nxt = 1'b0;
        ot_nxt = ot_r;
        if (in_valid) begin
            if (!avg_en) begin
                ov_nxt = 1'b1; // see RQ2
                ot_nxt = in_temp;
                acc_nxt = '0;
                cnt_nxt = '0;
            end else if (cnt_r == `DTRF_AVG_LAST) begin
                ov_nxt = 1'b1; // see RQ2
                ot_nxt = sum[15:4];
                acc_nxt = '0;
                cnt_nxt = '0;
            end else begin
                acc_nxt = sum;
                cnt_nxt = cnt_r + 4'h1;
            end
        end
    end

    // Register the accumulator and the output pulse.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            acc_r <= '0;
            cnt_r <= '0;
            ov_r <= 1'b0;
            ot_r <= '0;
        end else begin
            acc_r <= acc_nxt;
            cnt_r <= cnt_nxt;
            ov_r <= ov_nxt;
            ot_r <= ot_nxt;
        end
    end

    assign out_valid = ov_r;
    assign out_temp = ot_r;
endmodule // dtrf_averager

// ---- dtrf_formatter.sv ----
// Converts a quarter-degree result into binary or offset binary result bytes.
`timescale 1ns/10ps
`include "dtrf_params.svh"

module dtrf_formatter import dtrf_pkg::*; (
    input wire logic signed [11:0] temp,
    input wire logic ext_range,
    output dtrf_result_t res
);
    logic signed [9:0] ipart;
    logic signed [10:0] shifted;

    // Floor division keeps the two fraction bits positive for negative values.
    always_comb begin
        ipart = temp[11:2];
        shifted = {ipart[9], ipart} + $signed(`DTRF_EXT_OFS);
        res.int_b = ipart[7:0];
        res.frac_b = {temp[1:0], `DTRF_FRAC_PAD}; // see RQ5
        if (ext_range) begin
            if (shifted < 0) begin
                res.int_b = 8'h00;
                res.frac_b = 8'h00;
            end else if (shifted > $signed({3'h0, `DTRF_EXT_MAX})) begin
                res.int_b = `DTRF_EXT_MAX;
                res.frac_b = 8'h00;
            end else begin
                res.int_b = shifted[7:0]; // see RQ11
            end
        end else if (temp < 0) begin
            res.int_b = 8'h00; // see RQ12
            res.frac_b = 8'h00;
        end else if (ipart > $signed({2'h0, `DTRF_BIN_MAX})) begin
            res.int_b = `DTRF_BIN_MAX; // see RQ12
            res.frac_b = 8'h00;
        end
    end
endmodule // dtrf_formatter

// ---- dtrf_core.sv ----
// Dual temperature result formatter: sequencing, averaging, result registers and limits.
//
// Summary of operation
// RQ1 - Each remote measurement steps excitation base, first multiple, base, second multiple.
// RQ2 - Rate codes up to eight per second average sixteen cycles; faster ones do not.
// RQ3 - Local result, whole degrees, sits in the byte at offset 0x00.
// RQ4 - Remote result splits into integer byte 0x01 and fraction byte 0x10.
// RQ5 - Fraction byte holds quarter degrees in its top two bits, rest zero.
// RQ6 - Reading the fraction byte freezes the integer byte until it is read.
// RQ7 - Host reads the fraction byte before the integer byte for a coherent value.
// RQ8 - Configuration bit 2 selects extended range; zero selects zero to 127 degrees.
// RQ9 - After a range change the next measurement cycle gives a valid result.
// RQ10 - A shorted remote diode leaves the last good remote result in place.
// RQ11 - Extended range stores both results as offset binary, plus 64 degrees.
// RQ12 - Binary range clamps results to zero and 127 degrees.
// RQ13 - The first result after a range switch uses the new format.
// RQ14 - A range change leaves the stored limits untouched.
// RQ15 - Host rewrites the limits in the new format after a range change.
// RQ16 - Each stored result is compared against its high and low limits.
// RQ17 - The register space is built of eight-bit registers.
// RQ18 - Conversions run freely, alternating local and remote channels.
// RQ19 - Configuration reads at 0x03 and is written at 0x09.
// RQ20 - Result registers reset to 0x00 and only the converter writes them.
// RQ21 - Reading the integer byte frees the lock and loads the newest measurement.
`timescale 1ns/10ps
`include "dtrf_params.svh"

module dtrf_core import dtrf_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire dtrf_sample_t adc_in,
    output logic adc_req,
    output dtrf_exc_t exc_sel,
    output logic chan_remote,
    output dtrf_flags_t limit_flags
);
    localparam logic [7:0] PHASE_LAST = 8'(`DTRF_PHASE_CYC - 1);

    // Limit index decode; the low bytes share one offset for read and write.
    function automatic logic [3:0] lim_decode(input logic [7:0] a, input logic wr);
        logic [3:0] r;
        r = 4'h0;
        case (a)
            `DTRF_A_RHI_L: r = {1'b1, `DTRF_LIM_RHI_L};
            `DTRF_A_RLO_L: r = {1'b1, `DTRF_LIM_RLO_L};
            default: begin
                if (wr) begin
                    case (a)
                        `DTRF_A_LHI_WR: r = {1'b1, `DTRF_LIM_LHI};
                        `DTRF_A_LLO_WR: r = {1'b1, `DTRF_LIM_LLO};
                        `DTRF_A_RHI_H_WR: r = {1'b1, `DTRF_LIM_RHI_H};
                        `DTRF_A_RLO_H_WR: r = {1'b1, `DTRF_LIM_RLO_H};
                        default: r = 4'h0;
                    endcase
                end else begin
                    case (a)
                        `DTRF_A_LHI_RD: r = {1'b1, `DTRF_LIM_LHI};
                        `DTRF_A_LLO_RD: r = {1'b1, `DTRF_LIM_LLO};
                        `DTRF_A_RHI_H_RD: r = {1'b1, `DTRF_LIM_RHI_H};
                        `DTRF_A_RLO_H_RD: r = {1'b1, `DTRF_LIM_RLO_H};
                        default: r = 4'h0;
                    endcase
                end
            end
        endcase
        return r;
    endfunction

    // Ten-bit remote value in quarter degrees from an integer and a fraction byte.
    function automatic logic [9:0] rem10(input logic [7:0] ib, input logic [7:0] fb);
        return {ib, fb[7:6]};
    endfunction

    dtrf_state_t st_r, st_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic chan_r, chan_nxt, req_r, req_nxt;
    dtrf_exc_t exc_r, exc_nxt;
    logic [7:0] cfg_r, cfg_nxt, rate_r, rate_nxt;
    logic [7:0] lim_r [`DTRF_LIM_NUM]; // see RQ17
    logic [7:0] lim_nxt [`DTRF_LIM_NUM];
    logic [7:0] loc_r, loc_nxt, rint_r, rint_nxt, rfrac_r, rfrac_nxt;
    logic [7:0] pend_r, pend_nxt, rdata_r, rdata_nxt;
    logic lock_r, lock_nxt, pendv_r, pendv_nxt;
    dtrf_flags_t flags_r, flags_nxt;
    logic standby, ext_range, avg_en, sample_done, loc_in_v, rem_in_v;
    logic loc_v, rem_v, rd_int, rd_frac;
    logic signed [11:0] loc_t, rem_t, fmt_t;
    logic [3:0] wdec, rdec;
    dtrf_result_t fmt;

    assign standby = cfg_r[`DTRF_CFG_STANDBY];
    assign ext_range = cfg_r[`DTRF_CFG_RANGE]; // see RQ8
    assign avg_en = (rate_r[3:0] <= `DTRF_AVG_MAX_CODE); // see RQ2
    assign sample_done = (st_r == DTRF_CONV) && adc_in.valid;
    assign loc_in_v = sample_done && !chan_r;
    // A shorted remote sample is never averaged, so the last good result stays.
    assign rem_in_v = sample_done && chan_r && !adc_in.short_flag; // see RQ10

    // Measurement sequencer: four excitation steps, then one conversion request.
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        chan_nxt = chan_r;
        req_nxt = 1'b0;
        case (st_r)
            DTRF_IDLE: begin
                cnt_nxt = '0;
                if (!standby) st_nxt = DTRF_BASE1;
            end
            DTRF_BASE1, DTRF_MULT1, DTRF_BASE2, DTRF_MULT2: begin
                if (cnt_r == PHASE_LAST) begin
                    cnt_nxt = '0;
                    case (st_r)
                        DTRF_BASE1: st_nxt = DTRF_MULT1; // see RQ1
                        DTRF_MULT1: st_nxt = DTRF_BASE2;
                        DTRF_BASE2: st_nxt = DTRF_MULT2; // see RQ1
                        default: begin
                            st_nxt = DTRF_CONV;
                            req_nxt = 1'b1;
                        end
                    endcase
                end else begin
                    cnt_nxt = cnt_r + 8'h01;
                end
            end
            DTRF_CONV: begin
                if (adc_in.valid) begin
                    chan_nxt = !chan_r; // see RQ18
                    st_nxt = standby ? DTRF_IDLE : DTRF_BASE1;
                end
            end
            default: st_nxt = DTRF_IDLE;
        endcase
        case (st_nxt)
            DTRF_MULT1: exc_nxt = DTRF_EXC_N1;
            DTRF_MULT2: exc_nxt = DTRF_EXC_N2;
            default: exc_nxt = DTRF_EXC_BASE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r <= DTRF_IDLE;
            cnt_r <= '0;
            chan_r <= 1'b0;
            req_r <= 1'b0;
            exc_r <= DTRF_EXC_BASE;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            chan_r <= chan_nxt;
            req_r <= req_nxt;
            exc_r <= exc_nxt;
        end
    end

    dtrf_averager u_avg_loc (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(loc_in_v),
        .in_temp(adc_in.temp),
        .avg_en(avg_en),
        .out_valid(loc_v),
        .out_temp(loc_t)
    );

    dtrf_averager u_avg_rem (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(rem_in_v),
        .in_temp(adc_in.temp),
        .avg_en(avg_en),
        .out_valid(rem_v),
        .out_temp(rem_t)
    );

    // Formatting happens at store time, so a new range shows in the next result.
    assign fmt_t = loc_v ? loc_t : rem_t; // see RQ9
    dtrf_formatter u_fmt (
        .temp(fmt_t),
        .ext_range(ext_range), // see RQ13
        .res(fmt)
    );

    assign rd_int = reg_rd && (reg_addr == `DTRF_A_REM_INT);
    assign rd_frac = reg_rd && (reg_addr == `DTRF_A_REM_FRAC);
    assign wdec = reg_wr ? lim_decode(reg_addr, 1'b1) : 4'h0;
    assign rdec = lim_decode(reg_addr, 1'b0);

    // Register file; results are never touched by bus writes.
    always_comb begin
        cfg_nxt = cfg_r;
        rate_nxt = rate_r;
        lim_nxt = lim_r;
        loc_nxt = loc_r;
        rint_nxt = rint_r;
        rfrac_nxt = rfrac_r;
        pend_nxt = pend_r;
        pendv_nxt = pendv_r;
        lock_nxt = lock_r;
        if (reg_wr && reg_addr == `DTRF_A_CFG_WR) cfg_nxt = reg_wdata & `DTRF_CFG_WMASK; // see RQ19
        if (reg_wr && reg_addr == `DTRF_A_RATE_WR) rate_nxt = reg_wdata & `DTRF_RATE_MASK;
        // A range change rewrites nothing here, limits keep their old encoding.
        if (wdec[3]) lim_nxt[wdec[2:0]] = reg_wdata; // see RQ14
        if (loc_v) loc_nxt = fmt.int_b; // see RQ3
        // Reading the integer byte releases the lock and hands over the held value.
        if (rd_int && lock_r) begin
            lock_nxt = 1'b0; // see RQ21
            pendv_nxt = 1'b0;
            if (pendv_r) rint_nxt = pend_r; // see RQ21
        end
        if (rd_frac) lock_nxt = 1'b1; // see RQ6
        if (rem_v) begin
            rfrac_nxt = fmt.frac_b; // see RQ4
            // A frac read in this very cycle saw the old pair, so park the integer.
            if ((lock_r || rd_frac) && !rd_int) begin
                pend_nxt = fmt.int_b; // see RQ6
                pendv_nxt = 1'b1;
            end else begin
                rint_nxt = fmt.int_b; // see RQ4
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg_r <= `DTRF_CFG_RST;
            rate_r <= `DTRF_RATE_RST;
            lim_r[`DTRF_LIM_LHI] <= `DTRF_LIM_HI_RST;
            lim_r[`DTRF_LIM_LLO] <= `DTRF_LIM_LO_RST;
            lim_r[`DTRF_LIM_RHI_H] <= `DTRF_LIM_HI_RST;
            lim_r[`DTRF_LIM_RHI_L] <= `DTRF_LIM_LO_RST;
            lim_r[`DTRF_LIM_RLO_H] <= `DTRF_LIM_LO_RST;
            lim_r[`DTRF_LIM_RLO_L] <= `DTRF_LIM_LO_RST;
            loc_r <= `DTRF_RES_RST; // see RQ20
            rint_r <= `DTRF_RES_RST;
            rfrac_r <= `DTRF_RES_RST;
            pend_r <= `DTRF_RES_RST;
            pendv_r <= 1'b0;
            lock_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            rate_r <= rate_nxt;
            lim_r <= lim_nxt;
            loc_r <= loc_nxt;
            rint_r <= rint_nxt;
            rfrac_r <= rfrac_nxt;
            pend_r <= pend_nxt;
            pendv_r <= pendv_nxt;
            lock_r <= lock_nxt;
        end
    end

    // Read data and limit comparisons; high is strictly above, low is at or below.
    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd) begin
            case (reg_addr)
                `DTRF_A_LOCAL: rdata_nxt = loc_r;
                `DTRF_A_REM_INT: rdata_nxt = rint_r;
                `DTRF_A_REM_FRAC: rdata_nxt = rfrac_r;
                `DTRF_A_CFG_RD: rdata_nxt = cfg_r; // see RQ19
                `DTRF_A_RATE_RD: rdata_nxt = rate_r;
                default: rdata_nxt = rdec[3] ? lim_r[rdec[2:0]] : 8'h00;
            endcase
        end
        flags_nxt.loc_high = loc_r > lim_r[`DTRF_LIM_LHI]; // see RQ16
        flags_nxt.loc_low = loc_r <= lim_r[`DTRF_LIM_LLO];
        flags_nxt.rem_high = rem10(rint_r, rfrac_r) >
            rem10(lim_r[`DTRF_LIM_RHI_H], lim_r[`DTRF_LIM_RHI_L]); // see RQ16
        flags_nxt.rem_low = rem10(rint_r, rfrac_r) <=
            rem10(lim_r[`DTRF_LIM_RLO_H], lim_r[`DTRF_LIM_RLO_L]);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_r <= 8'h00;
            flags_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
            flags_r <= flags_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign adc_req = req_r;
    assign exc_sel = exc_r;
    assign chan_remote = chan_r;
    assign limit_flags = flags_r;

    // Checks on the sequencing, the lock and the result formats.
    a_exc_order: assert property (@(posedge clk_sys) disable iff (rst)
        (st_r == DTRF_MULT1) |-> (exc_r == DTRF_EXC_N1) && $past(exc_r) != DTRF_EXC_N2)
        else $error("first multiple not applied after base"); // see RQ1
    a_chan_alt: assert property (@(posedge clk_sys) disable iff (rst)
        sample_done |=> chan_r != $past(chan_r))
        else $error("channel did not alternate"); // see RQ18
    a_lock_set: assert property (@(posedge clk_sys) disable iff (rst)
        rd_frac ##1 !rd_int [*2] |-> lock_r && $stable(rint_r))
        else $error("integer byte changed while locked"); // see RQ6
    a_unlock_load: assert property (@(posedge clk_sys) disable iff (rst)
        (rd_int && lock_r && pendv_r && !rem_v) |=> (rint_r == $past(pend_r)) && !lock_r)
        else $error("lock release did not load held value"); // see RQ21
    a_frac_low: assert property (@(posedge clk_sys) disable iff (rst)
        rfrac_r[5:0] == 6'h00)
        else $error("fraction low bits not zero"); // see RQ5
    a_bin_sat: assert property (@(posedge clk_sys) disable iff (rst)
        (loc_v && !ext_range) |=> !loc_r[7])
        else $error("binary result above 127"); // see RQ12
    a_ext_offset: assert property (@(posedge clk_sys) disable iff (rst)
        (loc_v && ext_range && loc_t == 12'sh028) |=> loc_r == 8'h4A)
        else $error("ten degrees not encoded as offset binary"); // see RQ11
    a_short_keep: assert property (@(posedge clk_sys) disable iff (rst)
        (sample_done && chan_r && adc_in.short_flag) |=> !rem_v ##1 $stable(rfrac_r))
        else $error("shorted sample reached the remote result"); // see RQ10
    a_res_ro: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_wr && !loc_v && reg_addr == `DTRF_A_LOCAL) |=> $stable(loc_r))
        else $error("bus write changed the local result"); // see RQ20
    a_cfg_rd: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_rd && reg_addr == `DTRF_A_CFG_RD) |=> reg_rdata == $past(cfg_r))
        else $error("configuration readback wrong"); // see RQ19
    a_high_cmp: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 limit_flags.loc_high == ($past(loc_r) > $past(lim_r[`DTRF_LIM_LHI])))
        else $error("local high comparison wrong"); // see RQ16

    c_lock_pend: cover property (@(posedge clk_sys) disable iff (rst) rd_int && lock_r && pendv_r);
    c_short: cover property (@(posedge clk_sys) disable iff (rst) sample_done && adc_in.short_flag);
    c_ext_store: cover property (@(posedge clk_sys) disable iff (rst) rem_v && ext_range);
    c_avg_out: cover property (@(posedge clk_sys) disable iff (rst) loc_v && avg_en);
endmodule // dtrf_core

// ---- dtrf_adc_model.sv ----
// Behavioural converter that answers the formatter's conversion requests.
`timescale 1ns/10ps

module dtrf_adc_model import dtrf_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic adc_req,
    input wire logic chan_remote,
    input wire logic signed [11:0] loc_q,
    input wire logic signed [11:0] rem_q,
    input wire logic rem_short,
    input wire logic [3:0] lat,
    output dtrf_sample_t adc_in
);
    logic [4:0] cnt_r;

    // Answer lat plus one cycles after a request; the temperature toggles between answers.
    // A stale value must never pass for a fresh one.
    always @(posedge clk_sys) begin
        if (rst) begin
            cnt_r <= 5'h00;
            adc_in <= '0;
        end else begin
            if (adc_req) begin
                cnt_r <= {1'b0, lat} + 5'h01;
            end else if (cnt_r != 5'h00) begin
                cnt_r <= cnt_r - 5'h01;
            end
            adc_in.valid <= (cnt_r == 5'h01);
            adc_in.short_flag <= (cnt_r == 5'h01) && chan_remote && rem_short;
            adc_in.temp <= (cnt_r == 5'h01) ? (chan_remote ? rem_q : loc_q) : ~adc_in.temp;
        end
    end
endmodule // dtrf_adc_model

// ---- dual_temp_result_formatter_tb.sv ----
// Self-checking testbench of the dual temperature result formatter.
`timescale 1ns/10ps
`include "dtrf_params.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; $display("Error at %0t: got %h expected %h", $time, g, e); end end

module dual_temp_result_formatter_tb import dtrf_pkg::*; ;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rem_short = 1'b0;
    logic prev_ch = 1'b1;
    logic want_n2 = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [7:0] rd;
    logic signed [11:0] loc_q = 12'sh000;
    logic signed [11:0] rem_q = 12'sh000;
    logic [3:0] lat = 4'h0;
    logic [15:0] e;
    logic ext;
    logic adc_req;
    logic chan_remote;
    dtrf_sample_t adc_in;
    dtrf_exc_t exc_sel;
    dtrf_exc_t exc_prev = DTRF_EXC_BASE;
    dtrf_flags_t limit_flags;
    int n_mismatch = 0;
    int n_tests = 0;
    int n_smp = 0;

    // Free-running 100 MHz clock.
    always #5 clk_sys = ~clk_sys;

    dtrf_core dut_u (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_in(adc_in),
        .adc_req(adc_req), .exc_sel(exc_sel), .chan_remote(chan_remote),
        .limit_flags(limit_flags));
    dtrf_adc_model adc_u (.clk_sys(clk_sys), .rst(rst), .adc_req(adc_req),
        .chan_remote(chan_remote), .loc_q(loc_q), .rem_q(rem_q), .rem_short(rem_short),
        .lat(lat), .adc_in(adc_in));

    // Each taken sample must be on the other channel than the one before.
    always @(posedge clk_sys) begin
        if (!rst && adc_in.valid) begin
            `CHK(chan_remote, ~prev_ch)
            prev_ch = chan_remote;
            n_smp++;
        end
    end

    // Multiples must alternate first, second; a request may only follow the second.
    always @(posedge clk_sys) begin
        if (!rst && exc_sel != exc_prev && exc_sel != DTRF_EXC_BASE) begin
            `CHK(exc_sel, want_n2 ? DTRF_EXC_N2 : DTRF_EXC_N1)
            want_n2 = !want_n2;
        end
        exc_prev = exc_sel;
        if (!rst && adc_req) `CHK(want_n2, 1'b0)
    end

    // Expected {integer, fraction} bytes of a quarter-degree value.
    function automatic logic [15:0] fmt(input logic signed [11:0] t, input logic x);
        int v;
        v = x ? int'(t) + 256 : int'(t);
        if (v < 0) return 16'h0000;
        if (!x && v > 511) return 16'h7F00;
        if (v > 1023) return 16'hFF00;
        return {v[9:2], v[1:0], 6'h00};
    endfunction

    task automatic test_done();
        $display("Counts: %0d mismatches in %0d comparisons", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // One register access; read data is captured the cycle after the strobe.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        reg_wr = wr;
        reg_rd = !wr;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk_sys);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        rd = reg_rdata;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] x);
        bus(1'b0, a, 8'h00);
        `CHK(rd, x)
    endtask

    // Bounded wait for n more taken samples, then let the results land.
    task automatic wait_smp(input int n);
        int c;
        int s;
        c = 0;
        s = n_smp;
        while (n_smp < s + n && c < 40000) begin
            @(posedge clk_sys);
            c++;
        end
        if (c >= 40000) begin
            n_mismatch++;
            test_done();
        end
        repeat (4) @(posedge clk_sys);
        #1;
    endtask

    // Main sequence: reset values, limits, formats, lock, short diode, averaging.
    initial begin
        void'($urandom(32'h72A96B93));
        repeat (5) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        rchk(`DTRF_A_CFG_RD, 8'h00);
        rchk(`DTRF_A_RATE_RD, 8'h08);
        bus(1'b1, `DTRF_A_LOCAL, 8'hAA);
        bus(1'b1, `DTRF_A_REM_INT, 8'hAA);
        bus(1'b1, `DTRF_A_REM_FRAC, 8'hAA);
        rchk(`DTRF_A_LOCAL, 8'h00);
        rchk(`DTRF_A_REM_FRAC, 8'h00);
        rchk(`DTRF_A_REM_INT, 8'h00);
        bus(1'b1, `DTRF_A_CFG_WR, 8'h1B);
        rchk(`DTRF_A_CFG_RD, 8'h00);
        rchk(8'h30, 8'h00);
        $display("Reset and access test done");
        bus(1'b1, `DTRF_A_LHI_WR, 8'h05);
        loc_q = 12'sd40;
        rem_q = 12'sd100;
        wait_smp(3);
        `CHK(limit_flags, 4'b1000)
        bus(1'b1, `DTRF_A_CFG_WR, 8'h04);
        rchk(`DTRF_A_LHI_RD, 8'h05);
        bus(1'b1, `DTRF_A_LHI_WR, 8'h45);
        wait_smp(3);
        rchk(`DTRF_A_LOCAL, 8'h4A);
        rchk(`DTRF_A_REM_INT, 8'h59);
        `CHK(limit_flags, 4'b1010)
        $display("Limit and range test done");
        // Random values in both formats, the first two fixed on the binary clamps.
        for (int i = 0; i < 12; i++) begin
            ext = (i < 2) ? 1'b0 : 1'($urandom_range(1));
            loc_q = (i < 2) ? -12'sd1 : 12'(int'($urandom_range(1023)) - 256);
            rem_q = (i == 0) ? 12'sd511 : (i == 1) ? 12'sd512 : 12'(int'($urandom_range(1023)) - 256);
            lat = 4'($urandom_range(15));
            bus(1'b1, `DTRF_A_CFG_WR, {5'h00, ext, 2'h0});
            wait_smp(3);
            e = fmt(rem_q, ext);
            rchk(`DTRF_A_REM_FRAC, e[7:0]); // and
            rchk(`DTRF_A_REM_INT, e[15:8]);
            e = fmt(loc_q, ext);
            rchk(`DTRF_A_LOCAL, e[15:8]);
        end
        $display("Format test done");
        bus(1'b1, `DTRF_A_CFG_WR, 8'h00);
        rem_q = 12'sd41;
        wait_smp(3);
        rchk(`DTRF_A_REM_FRAC, 8'h40);
        rem_q = 12'sd203;
        wait_smp(3);
        rchk(`DTRF_A_REM_INT, 8'h0A);
        rchk(`DTRF_A_REM_FRAC, 8'hC0);
        rchk(`DTRF_A_REM_INT, 8'h32);
        rem_short = 1'b1;
        rem_q = 12'sd400;
        wait_smp(3);
        rchk(`DTRF_A_REM_INT, 8'h32);
        rem_short = 1'b0;
        $display("Lock and short test done");
        rem_q = 12'sd120;
        loc_q = 12'sd100;
        bus(1'b1, `DTRF_A_RATE_WR, 8'h07);
        wait_smp(66);
        rchk(`DTRF_A_LOCAL, 8'h19);
        rchk(`DTRF_A_REM_INT, 8'h1E);
        loc_q = 12'sd300;
        wait_smp(4);
        rchk(`DTRF_A_LOCAL, 8'h19);
        $display("Averaging test done");
        test_done();
    end
endmodule // dual_temp_result_formatter_tb
